// file: design/sci_break_defines.svh
// Timing and frame constants for the break and idle transmitter.
// Assumes a single 250 MHz clock and a fixed programmed baud rate.
`ifndef SCI_BREAK_DEFINES_SVH
`define SCI_BREAK_DEFINES_SVH

// Clock rate in Hz and line rate in baud
`define SBI_CLOCK_HZ       250000000
`define SBI_BAUD_RATE      19200
// Cycles in one bit period, rounded down
`define SBI_CYCLES_PER_BIT (`SBI_CLOCK_HZ / `SBI_BAUD_RATE)

// Bit periods per character for each word-length select value
`define SBI_FRAME_BITS_8   4'ha
`define SBI_FRAME_BITS_9   4'hb
// High bit periods closing each break character
`define SBI_STOP_BITS      4'h1

// Reset value of the serial output line (marking)
`define SBI_LINE_RESET     1'b1

`endif

// file: design/sci_break_pkg.sv
// Types shared by the break and idle transmitter modules.
// Assumes nothing beyond the defines header.
package sci_break_pkg;

  // Transmit sequencer states
  typedef enum logic [1:0] {
    S_READY,
    S_IDLE_FRAME,
    S_BREAK,
    S_BREAK_STOP
  } tx_state_t;

  // Bit-count width used on the timer request
  typedef logic [3:0] bit_count_t;

endpackage : sci_break_pkg

// file: design/bit_timer_if.sv
// Interface between the transmit sequencer and its bit-period timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none

interface bit_timer_if;
  import sci_break_pkg::*;
  logic       start;  // Load a new run of bit periods
  bit_count_t bits;   // Number of bit periods to run
  logic       done;   // Last cycle of the run
  logic       busy;   // A run is in progress

  modport ctrl  (output start, output bits, input done, input busy);
  modport timer (input start, input bits, output done, output busy);
endinterface : bit_timer_if

`default_nettype wire

// file: design/sci_bit_timer.sv
// Bit-period timer: counts a requested number of whole bit periods.
// Assumes start is synchronous and may arrive in the done cycle.
`timescale 1ns/1ps
`default_nettype none

module sci_bit_timer #(
  parameter int unsigned CYCLES_PER_BIT = 13020
) (
  input  wire logic clock,   // Core clock
  input  wire logic rst_n,   // Synchronised reset, active low
  bit_timer_if.timer tmr     // Request from the sequencer
);
  import sci_break_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES_PER_BIT) + 1;
  localparam logic [CW-1:0] LAST_CYC = CW'(CYCLES_PER_BIT - 1);

  logic [CW-1:0] cyc_ff;
  bit_count_t    left_ff;
  logic          busy_ff;
  logic          bit_end;

  //////////////////////////////////////////////////////////////////////////
  // End of a bit period and of the whole run
  assign bit_end  = busy_ff && (cyc_ff == LAST_CYC);
  assign tmr.done = bit_end && (left_ff == 4'h1);
  assign tmr.busy = busy_ff;

  // Cycle counter within a bit period
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cyc_ff <= '0;
    else if (tmr.start || bit_end)
      cyc_ff <= '0;
    else if (busy_ff)
      cyc_ff <= cyc_ff + 1'b1;
  end

  // Remaining bit periods and run flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_ff <= 4'h0;
      busy_ff <= 1'b0;
    end
    else if (tmr.start)
    begin
      left_ff <= tmr.bits;
      busy_ff <= 1'b1;
    end
    else if (bit_end)
    begin
      left_ff <= left_ff - 4'h1;
      busy_ff <= (left_ff != 4'h1);
    end
  end

endmodule : sci_bit_timer

`default_nettype wire

// file: design/sci_break_idle_transmit.sv
// Transmit-side break and idle generator of an asynchronous serial port.
// Assumes control inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sci_break_defines.svh"

module sci_break_idle_transmit #(
  parameter int unsigned CYCLES_PER_BIT = `SBI_CYCLES_PER_BIT
) (
  input  wire logic clock,               // Core clock, 250 MHz
  input  wire logic arst_n,              // Asynchronous reset, active low
  input  wire logic send_break_request,  // Host break request level
  input  wire logic transmitter_enable,  // Host transmitter enable
  input  wire logic word_length_select,  // 0: 8 data bits, 1: 9
  output logic      tx_line_ff,          // Serial output line
  output logic      break_active_ff,     // Break low period in progress
  output logic      idle_active_ff       // Idle frame in progress
);
  import sci_break_pkg::*;

  logic       rst_meta_ff;
  logic       rst_n_ff;
  tx_state_t  state_ff;
  tx_state_t  nxt_state;
  logic       te_prev_ff;
  logic       idle_pend_ff;
  logic       brk_latch_ff;
  logic       want_break;
  bit_count_t frame_bits;
  logic       req_prev_ff;
  logic       te_rise;
  logic       req_rise;
  logic       idle_due;
  logic       idle_start;
  logic       break_start;

  // Request and done lines of the bit-period timer
  bit_timer_if tmr ();

  //////////////////////////////////////////////////////////////////////////
  // True when the sequencer launches a timer run for the given frame kind;
  // used to retire the queued idle and the latched break request
  function automatic logic starts_frame(input logic      start,
                                        input tx_state_t nxt,
                                        input tx_state_t kind);
    return start && (nxt == kind);
  endfunction : starts_frame

  //////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bit-period timer
  sci_bit_timer #(
    .CYCLES_PER_BIT (CYCLES_PER_BIT)
  ) u_timer (
    .clock (clock),
    .rst_n (rst_n_ff),
    .tmr   (tmr)
  );

  //////////////////////////////////////////////////////////////////////////
  // Character length from the word-length select
  assign frame_bits = word_length_select ? `SBI_FRAME_BITS_9
                                         : `SBI_FRAME_BITS_8;

  // Break wanted by a held level or a latched short pulse
  assign want_break = send_break_request || brk_latch_ff;

  //////////////////////////////////////////////////////////////////////////
  // Request edges; both history flops reset to the idle level of 0
  assign te_rise  = transmitter_enable && !te_prev_ff;
  assign req_rise = send_break_request && !req_prev_ff;

  // Idle owed: queued earlier or asked for at this very edge
  assign idle_due = idle_pend_ff || te_rise;

  // Frame launches seen by the bookkeeping flops
  assign idle_start  = starts_frame(tmr.start, nxt_state, S_IDLE_FRAME);
  assign break_start = starts_frame(tmr.start, nxt_state, S_BREAK);

  // Enable history for edge detection
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      te_prev_ff <= 1'b0;
    else
      te_prev_ff <= transmitter_enable;
  end

  // Break request history for edge detection
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      req_prev_ff <= 1'b0;
    else
      req_prev_ff <= send_break_request;
  end

  // Idle owed until its frame starts; a rise served at once is not kept
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      idle_pend_ff <= 1'b0;
    else if (idle_start)
      idle_pend_ff <= 1'b0;
    else if (te_rise)
      idle_pend_ff <= 1'b1;
  end

  // New request met while busy; a level held past its start adds nothing,
  // so clearing the request mid-break never costs an extra break
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      brk_latch_ff <= 1'b0;
    else if (break_start)
      brk_latch_ff <= 1'b0;
    else if (req_rise)
      brk_latch_ff <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state; one timer run per frame, no restart mid-run
  always_comb
  begin
    nxt_state = state_ff;
    tmr.start = 1'b0;
    tmr.bits  = frame_bits;
    unique case (state_ff)
      S_READY, S_IDLE_FRAME, S_BREAK_STOP:
      begin
        if (state_ff == S_READY || tmr.done)
        begin
          if (state_ff != S_READY)
            nxt_state = S_READY;
          // Idle first, so a held request cannot overtake a fresh enable
          if (transmitter_enable && idle_due)
          begin
            nxt_state = S_IDLE_FRAME;
            tmr.start = 1'b1;
          end
          else if (transmitter_enable && want_break)
          begin
            nxt_state = S_BREAK;
            tmr.start = 1'b1;
          end
        end
      end
      S_BREAK:
      begin
        if (tmr.done)
        begin
          nxt_state = S_BREAK_STOP;
          tmr.start = 1'b1;
          tmr.bits  = `SBI_STOP_BITS;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      state_ff <= S_READY;
    else
      state_ff <= nxt_state;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs registered from the next state, so edges align with the timer
  // Serial line: low only through the break body
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      tx_line_ff <= `SBI_LINE_RESET;
    else
      tx_line_ff <= (nxt_state != S_BREAK);
  end

  // Break flag, high exactly while the line is held low
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      break_active_ff <= 1'b0;
    else
      break_active_ff <= (nxt_state == S_BREAK);
  end

  // Idle flag over the high idle frame
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      idle_active_ff <= 1'b0;
    else
      idle_active_ff <= (nxt_state == S_IDLE_FRAME);
  end

endmodule : sci_break_idle_transmit

`default_nettype wire

// file: tb/sci_break_asserts.sv
// Port checker for the break and idle transmitter.
// Assumes binding onto the top module; one clock.
`timescale 1ns/1ps
`default_nettype none

module sci_break_asserts #(
  parameter int unsigned CYCLES_PER_BIT = 4
) (
  input wire logic clock,              // Core clock
  input wire logic arst_n,             // Reset, active low
  input wire logic send_break_request, // Break request
  input wire logic transmitter_enable, // Enable
  input wire logic word_length_select, // Word length
  input wire logic tx_line_ff,         // Serial line
  input wire logic break_active_ff,    // Break flag
  input wire logic idle_active_ff      // Idle flag
);
  localparam int IDLE_WIN = 12 * CYCLES_PER_BIT;
  int unsigned low_cnt_ff;
  logic        long_ff;
  logic        brk_q_ff;
  logic        pend_ff;

  // Break length, word length and outstanding request
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      low_cnt_ff <= 0;
      long_ff    <= 1'b0;
      brk_q_ff   <= 1'b0;
      pend_ff    <= 1'b0;
    end
    else
    begin
      low_cnt_ff <= break_active_ff ? low_cnt_ff + 1 : 0;
      brk_q_ff   <= break_active_ff;
      if (!break_active_ff)
        long_ff <= word_length_select;
      if (break_active_ff && !brk_q_ff)
        pend_ff <= send_break_request;
      else if (send_break_request)
        pend_ff <= 1'b1;
    end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Stop bit, written for a bit period of 4 cycles
  sequence s_stop;
    tx_line_ff [*4];
  endsequence

  a_flag_line: assert property (break_active_ff == !tx_line_ff)
    else $error("break flag and line disagree");
  a_break_len: assert property ($fell(break_active_ff) |->
    low_cnt_ff == (long_ff ? 11 : 10) * CYCLES_PER_BIT)
    else $error("break length wrong");
  a_stop_high: assert property ($fell(break_active_ff) |-> s_stop)
    else $error("stop bit missing");
  a_back_to_back: assert property ($fell(break_active_ff) &&
    send_break_request |-> s_stop ##1 break_active_ff)
    else $error("held request did not repeat break");
  a_break_cause: assert property ($rose(break_active_ff) |-> pend_ff)
    else $error("break without request");
  a_idle_first: assert property ($rose(transmitter_enable) &&
    !break_active_ff |-> !break_active_ff throughout
    ##[1:IDLE_WIN] idle_active_ff)
    else $error("idle frame not sent first");
  a_start_en: assert property ($rose(break_active_ff) ||
    $rose(idle_active_ff) |-> $past(transmitter_enable))
    else $error("frame started while disabled");
endmodule : sci_break_asserts

bind sci_break_idle_transmit sci_break_asserts #(
  .CYCLES_PER_BIT(CYCLES_PER_BIT)
) u_sci_break_asserts (.*);

`default_nettype wire

// file: tb/sci_line_receiver.sv
// Remote receiver model: measures low periods of the line.
// Assumes the line is sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none

module sci_line_receiver (
  input  wire logic clock,      // Core clock
  input  wire logic rx_line,    // Line from transmitter
  output int        brk_cnt_ff, // Breaks seen
  output int        len_ff      // Low cycles of last break
);
  int low_ff = 0;

  // Counts each low stretch and logs it when the line returns high
  always_ff @(posedge clock)
    if (!rx_line)
      low_ff <= low_ff + 1;
    else if (low_ff != 0)
    begin
      brk_cnt_ff <= brk_cnt_ff + 1;
      len_ff     <= low_ff;
      low_ff     <= 0;
    end
endmodule : sci_line_receiver

`default_nettype wire

// file: tb/tb.sv
// Testbench for the break and idle transmitter.
// Assumes the checker is bound and a bit period of 4 cycles.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int CPB = 4;
  logic clock              = 1'b0;
  logic arst_n             = 1'b0;
  logic send_break_request = 1'b0;
  logic transmitter_enable = 1'b0;
  logic word_length_select = 1'b0;
  logic tx_line_ff;
  logic break_active_ff;
  logic idle_active_ff;
  int   brk_cnt_ff;
  int   len_ff;
  int   n_fail     = 0;
  int   num_checks = 0;
  int   cyc        = 0;

  sci_break_idle_transmit #(
    .CYCLES_PER_BIT (CPB)
  ) u_sci_break_idle_transmit (
    .clock              (clock),
    .arst_n             (arst_n),
    .send_break_request (send_break_request),
    .transmitter_enable (transmitter_enable),
    .word_length_select (word_length_select),
    .tx_line_ff         (tx_line_ff),
    .break_active_ff    (break_active_ff),
    .idle_active_ff     (idle_active_ff)
  );
  sci_line_receiver u_sci_line_receiver (.clock(clock), .rx_line(tx_line_ff),
    .brk_cnt_ff(brk_cnt_ff), .len_ff(len_ff));

  // Clock and hang limit
  initial
    forever #2 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      close_out();
    end
  end

  function automatic int exp_len(input logic w);
    return (w ? 11 : 10) * CPB;
  endfunction : exp_len

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // Enable low then high: an idle frame must begin
  task automatic idle_cycle();
    transmitter_enable = 1'b0;
    @(negedge clock);
    transmitter_enable = 1'b1;
    @(negedge clock);
    chk(idle_active_ff, 1'b1);
  endtask : idle_cycle

  // Hold the request over n break starts, then count them and time the last one
  task automatic send_breaks(input logic w, input int n);
    int c0;
    c0 = brk_cnt_ff;
    word_length_select = w;
    send_break_request = 1'b1;
    repeat (n) @(posedge break_active_ff);
    @(negedge clock);
    send_break_request = 1'b0;
    repeat (60) @(negedge clock);
    chk(brk_cnt_ff - c0, n);
    chk(len_ff, exp_len(w));
  endtask : send_breaks

  // Main sequence: corners first, then random runs
  initial
  begin
    int seed_v;
    seed_v = $urandom(32'h17bd);
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    chk(tx_line_ff, 1'b1);
    idle_cycle();
    send_breaks(1'b0, 1);
    send_breaks(1'b1, 1);
    send_breaks(1'b0, 3);
    send_breaks(1'b1, 2);
    // Request raised together with the enable: idle still goes first
    transmitter_enable = 1'b0;
    @(negedge clock);
    send_break_request = 1'b1;
    transmitter_enable = 1'b1;
    @(negedge clock);
    chk(idle_active_ff, 1'b1);
    send_breaks(1'b0, 1);
    repeat (6)
    begin
      if ($urandom_range(1) == 1)
        idle_cycle();
      send_breaks(1'($urandom_range(1)), $urandom_range(3, 1));
    end
    close_out();
  end
endmodule : tb

`default_nettype wire
